// ===== core/otp_mirror_pkg.sv
package otp_mirror_pkg;

	localparam int unsigned CFG_W          = 16;
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned INIT_TMO_S     = 2;
	localparam int unsigned INIT_TMO_CYC   = CLK_HZ * INIT_TMO_S;
	localparam int unsigned BURN_CYC       = 16;
	localparam int unsigned WIN_INH_BIT    = 0;
	localparam int unsigned DEBUG_EXIT_BIT = 14;

	typedef enum logic [1:0]
	{
		SEC_NONE   = 2'h0,
		SEC_FIRST  = 2'h1,
		SEC_SECOND = 2'h3
	} sector_t;

	typedef enum logic [2:0]
	{
		ST_LOAD    = 3'h0,
		ST_HOLD    = 3'h1,
		ST_RUN     = 3'h3,
		ST_BURN    = 3'h2,
		ST_OFF     = 3'h6
	} ctrl_state_t;

	typedef struct packed
	{
		logic burn_main;
		logic burn_safe;
		logic wr_main;
		logic wr_safe;
		logic wr_user;
		logic exit_debug;
		logic exit_otp;
		logic enter_test;
	} host_cmd_t;

	typedef struct packed
	{
		logic user_mode;
		logic test_mode;
		logic otp_mode;
		logic debug_mode;
		logic emulated;
	} mode_status_t;

endpackage

// ===== core/fuse_block.sv
`timescale 1ns/1ps
// one fuse block: two write-once sectors plus burn record
module fuse_block
	import otp_mirror_pkg::*;
#(
	parameter int unsigned WIDTH = CFG_W
)
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             burn,
	input  wire logic [WIDTH-1:0] burn_data,
	output logic      [WIDTH-1:0] rd_data,
	output sector_t               used,
	output logic                  full
);
	initial
	begin
		if (WIDTH < 2)
			$error("fuse_block width too small");
	end

	// fuse cells keep state across rst: rst models the digital reset only
	// initial values model a blank part; rst must not touch them
	logic [WIDTH-1:0] first_fuse_sector_ff  = '0;
	logic [WIDTH-1:0] second_fuse_sector_ff = '0;
	sector_t          used_ff               = SEC_NONE;
	logic [WIDTH-1:0] rd_ff;

	always_ff @(posedge sys_clk)
	begin
		if (burn && used_ff == SEC_NONE)
			first_fuse_sector_ff <= burn_data;
		else if (burn && used_ff == SEC_FIRST)
			second_fuse_sector_ff <= burn_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (burn && used_ff == SEC_NONE)
			used_ff <= SEC_FIRST;
		else if (burn && used_ff == SEC_FIRST)
			used_ff <= SEC_SECOND;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rd_ff <= '0;
		else if (used_ff == SEC_SECOND)
			rd_ff <= second_fuse_sector_ff;
		else if (used_ff == SEC_FIRST)
			rd_ff <= first_fuse_sector_ff;
		else
			rd_ff <= '0;
	end

	assign rd_data = rd_ff;
	assign used    = used_ff;
	assign full    = (used_ff == SEC_SECOND);
endmodule

// ===== core/otp_mirror_mode_control.sv
`timescale 1ns/1ps
module otp_mirror_mode_control
	import otp_mirror_pkg::*;
#(
	parameter int unsigned WIDTH    = CFG_W,
	parameter int unsigned TMO_CYC  = INIT_TMO_CYC,
	parameter int unsigned BURN_LEN = BURN_CYC
)
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             debug_entry_pin,
	input  wire logic             restart,
	input  wire logic             deep_safe_state,
	input  wire logic             standby,
	input  wire host_cmd_t        cmd,
	input  wire logic [WIDTH-1:0] cmd_data,
	input  wire logic             safety_fault,
	input  wire logic             init_done,
	output logic      [WIDTH-1:0] main_mirror,
	output logic      [WIDTH-1:0] safe_mirror,
	output logic      [WIDTH-1:0] user_reg,
	output mode_status_t          status,
	output logic                  cmd_refused,
	output logic                  burn_busy,
	output sector_t               main_used,
	output sector_t               safe_used,
	output logic                  regulators_on,
	output logic                  power_up_start,
	output logic                  window_enable,
	output logic                  init_timeout,
	output logic                  safety_reaction,
	output logic                  safe_output_pin
);
	initial
	begin
		if (WIDTH <= DEBUG_EXIT_BIT || WIDTH <= WIN_INH_BIT)
			$error("config width too small");
		if (TMO_CYC < 1 || BURN_LEN < 1 || BURN_LEN > 65536)
			$error("counts out of range");
	end

	function automatic logic inhibit_of(input logic [WIDTH-1:0] cfg);
		return cfg[WIN_INH_BIT];
	endfunction

	// debug pin is asynchronous to sys_clk
	logic dbg_meta_ff;
	logic dbg_sync_ff;
	always_ff @(posedge sys_clk)
	begin
		dbg_meta_ff <= debug_entry_pin;
		dbg_sync_ff <= dbg_meta_ff;
	end

	logic [WIDTH-1:0] main_fuse;
	logic [WIDTH-1:0] safe_fuse;
	logic [WIDTH-1:0] main_mirror_ff;
	logic [WIDTH-1:0] safe_mirror_ff;
	logic             main_full;
	logic             safe_full;
	logic             burn_main_go;
	logic             burn_safe_go;

	fuse_block #(.WIDTH(WIDTH)) main_fuse_blk
	(
		.sys_clk   (sys_clk),
		.rst       (rst),
		.burn      (burn_main_go),
		.burn_data (main_mirror_ff),
		.rd_data   (main_fuse),
		.used      (main_used),
		.full      (main_full)
	);

	fuse_block #(.WIDTH(WIDTH)) safe_fuse_blk
	(
		.sys_clk   (sys_clk),
		.rst       (rst),
		.burn      (burn_safe_go),
		.burn_data (safe_mirror_ff),
		.rd_data   (safe_fuse),
		.used      (safe_used),
		.full      (safe_full)
	);

	ctrl_state_t state_ff;
	ctrl_state_t nxt_state;
	logic        otp_ff;
	logic        test_ff;
	logic        debug_ff;
	logic        emul_ff;
	logic        safe_out_ff;
	logic        burn_tgt_main_ff;
	logic [15:0] burn_cnt_ff;
	logic [$clog2(TMO_CYC+1)-1:0] tmo_cnt_ff;
	logic [WIDTH-1:0] user_ff;
	logic             load_pend_ff;
	logic             exit_req_ff;
	logic             regulators_prev_ff;
	logic             refused_ff;
	logic             pwr_ff;
	logic             tmo_ff;

	logic fuse_ok;
	logic mirror_wr_ok;
	logic burn_req;
	logic burn_ok;
	logic entry_evt;
	logic otp_exit;
	logic emul_clear;

	assign entry_evt    = (state_ff == ST_LOAD) || restart;
	assign fuse_ok      = test_ff || otp_ff;
	assign mirror_wr_ok = fuse_ok && state_ff != ST_BURN;
	assign burn_req     = cmd.burn_main || cmd.burn_safe;
	assign burn_ok      = otp_ff && state_ff == ST_HOLD
		&& !(cmd.burn_main && main_full) && !(cmd.burn_safe && safe_full);
	assign otp_exit     = otp_ff && (cmd.exit_otp || !dbg_sync_ff);
	assign emul_clear   = deep_safe_state || standby;
	assign burn_main_go = state_ff == ST_BURN && burn_tgt_main_ff
		&& burn_cnt_ff == 16'(BURN_LEN - 1);
	assign burn_safe_go = state_ff == ST_BURN && !burn_tgt_main_ff
		&& burn_cnt_ff == 16'(BURN_LEN - 1);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_LOAD:
				nxt_state = dbg_sync_ff ? ST_HOLD : ST_RUN;
			ST_HOLD:
			begin
				if (burn_req && burn_ok)
					nxt_state = ST_BURN;
				else if (otp_exit)
					nxt_state = ST_RUN;
			end
			ST_BURN:
				if (burn_cnt_ff == 16'(BURN_LEN - 1))
					nxt_state = ST_LOAD;
			ST_RUN:
				if (standby || deep_safe_state)
					nxt_state = ST_OFF;
			ST_OFF:
				if (!standby && !deep_safe_state)
					nxt_state = ST_LOAD;
			default:
				nxt_state = ST_LOAD;
		endcase
		if (restart && state_ff != ST_BURN)
			nxt_state = ST_LOAD;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_ff <= ST_LOAD;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || state_ff != ST_BURN)
			burn_cnt_ff <= '0;
		else
			burn_cnt_ff <= burn_cnt_ff + 16'h0001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			burn_tgt_main_ff <= 1'b0;
		else if (state_ff == ST_HOLD && burn_req)
			burn_tgt_main_ff <= cmd.burn_main;
	end

	// OTP mode: entered from the pin at startup, left by pin removal or command
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			otp_ff <= 1'b0;
		else if (state_ff == ST_LOAD && !restart)
			otp_ff <= dbg_sync_ff;
		else if (otp_exit && state_ff == ST_HOLD && !(burn_req && burn_ok))
			otp_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			debug_ff <= 1'b0;
		else if (otp_ff || (state_ff == ST_LOAD && dbg_sync_ff))
			debug_ff <= 1'b1;
		else if (cmd.exit_debug && cmd_data[DEBUG_EXIT_BIT])
			debug_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			test_ff <= 1'b0;
		else if (otp_ff || (state_ff == ST_LOAD && dbg_sync_ff))
			test_ff <= 1'b1;
		else if (cmd.enter_test && dbg_sync_ff)
			test_ff <= 1'b1;
		else if (entry_evt && !dbg_sync_ff)
			test_ff <= 1'b0;
	end

	// mirror: reload from fuse unless the host is emulating
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			emul_ff <= 1'b0;
		else if (emul_clear)
			emul_ff <= 1'b0;
		else if ((cmd.wr_main || cmd.wr_safe) && mirror_wr_ok)
			emul_ff <= 1'b1;
		else if (burn_main_go || burn_safe_go)
			emul_ff <= 1'b0;
	end

	// fuse read is registered, so the load waits one cycle after ST_LOAD
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			load_pend_ff <= 1'b0;
		else
			load_pend_ff <= state_ff == ST_LOAD;
	end

	// discarding emulation outranks a host write in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			main_mirror_ff <= '0;
		else if (emul_clear)
			main_mirror_ff <= main_fuse;
		else if (cmd.wr_main && mirror_wr_ok)
			main_mirror_ff <= cmd_data;
		else if (load_pend_ff && !emul_ff)
			main_mirror_ff <= main_fuse;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			safe_mirror_ff <= '0;
		else if (emul_clear)
			safe_mirror_ff <= safe_fuse;
		else if (cmd.wr_safe && mirror_wr_ok)
			safe_mirror_ff <= cmd_data;
		else if (load_pend_ff && !emul_ff)
			safe_mirror_ff <= safe_fuse;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			user_ff <= '0;
		else if (cmd.wr_user)
			user_ff <= cmd_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			refused_ff <= 1'b0;
		else
			refused_ff <= ((cmd.wr_main || cmd.wr_safe) && !mirror_wr_ok)
				|| (burn_req && !burn_ok);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pwr_ff <= 1'b0;
		else
			pwr_ff <= (nxt_state == ST_RUN);
	end

	// init safety timeout counts while waiting for the first good refresh
	always_ff @(posedge sys_clk)
	begin
		if (rst || state_ff != ST_RUN || init_done || debug_ff
			|| inhibit_of(safe_mirror_ff))
			tmo_cnt_ff <= '0;
		else if (tmo_cnt_ff != ($clog2(TMO_CYC+1))'(TMO_CYC))
			tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tmo_ff <= 1'b0;
		else
			tmo_ff <= tmo_cnt_ff == ($clog2(TMO_CYC+1))'(TMO_CYC);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			safe_out_ff <= 1'b1;
		else if (debug_ff || safety_fault)
			safe_out_ff <= 1'b1;
		else if (exit_req_ff && !debug_ff)
			safe_out_ff <= 1'b0;
	end

	// the exit strobe lasts one cycle; delay it by one cycle, by which time debug has dropped
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			exit_req_ff <= 1'b0;
		else
			exit_req_ff <= cmd.exit_debug && cmd_data[DEBUG_EXIT_BIT] && !otp_ff;
	end

	assign main_mirror      = main_mirror_ff;
	assign safe_mirror      = safe_mirror_ff;
	assign user_reg         = user_ff;
	assign status           = {!fuse_ok, test_ff, otp_ff, debug_ff, emul_ff};
	assign cmd_refused      = refused_ff;
	assign burn_busy        = state_ff == ST_BURN;
	assign regulators_on    = pwr_ff;
	assign power_up_start   = pwr_ff && !regulators_prev_ff;
	assign window_enable    = !debug_ff && !inhibit_of(safe_mirror_ff);
	assign init_timeout     = tmo_ff;
	assign safety_reaction  = safety_fault && !debug_ff;
	assign safe_output_pin  = safe_out_ff;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			regulators_prev_ff <= 1'b0;
		else
			regulators_prev_ff <= pwr_ff;
	end
endmodule

// ===== bench/host_model.sv
`timescale 1ns/1ps
module host_model
	import otp_mirror_pkg::*;
(
	input  wire logic        sys_clk,
	output host_cmd_t        cmd,
	output logic      [15:0] cmd_data
);
	initial
	begin
		cmd = '0;
		cmd_data = '0;
	end
	// released data is inverted so a stale word can never pass for a fresh one
	task send(host_cmd_t c, logic [15:0] d);
		@(posedge sys_clk);
		cmd <= c;
		cmd_data <= d;
		@(posedge sys_clk);
		cmd <= '0;
		cmd_data <= ~d;
	endtask
endmodule

// ===== bench/otp_mirror_chk.sv
`timescale 1ns/1ps
module otp_mirror_chk
	import otp_mirror_pkg::*;
#(
	parameter int unsigned WIDTH    = CFG_W,
	parameter int unsigned TMO_CYC  = INIT_TMO_CYC,
	parameter int unsigned BURN_LEN = BURN_CYC
)
(
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire host_cmd_t        cmd,
	input wire logic [WIDTH-1:0] cmd_data,
	input wire logic             safety_fault,
	input wire logic [WIDTH-1:0] main_mirror,
	input wire logic [WIDTH-1:0] safe_mirror,
	input wire mode_status_t     status,
	input wire logic             cmd_refused,
	input wire logic             burn_busy,
	input wire sector_t          main_used,
	input wire logic             regulators_on,
	input wire logic             power_up_start,
	input wire logic             window_enable,
	input wire logic             init_timeout,
	input wire logic             safety_reaction,
	input wire logic             safe_output_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [7:0] bcnt_ff;
	always_ff @(posedge sys_clk)
	begin
		if (rst || !burn_busy)
			bcnt_ff <= 8'h00;
		else
			bcnt_ff <= bcnt_ff + 8'h01;
	end
	AST_SAFETY: assert property (safety_reaction == (safety_fault && !status.debug_mode))
		else $error("safety reaction wrong");
	AST_WINDOW: assert property (window_enable == (!status.debug_mode && !safe_mirror[0]))
		else $error("window enable wrong");
	AST_OTP: assert property (status.otp_mode |-> status.debug_mode && status.test_mode && !regulators_on)
		else $error("otp mode side effects wrong");
	AST_PUP: assert property (power_up_start |-> regulators_on ##1 !power_up_start)
		else $error("power up pulse wrong");
	AST_FULL: assert property (cmd.burn_main && main_used == SEC_SECOND |=> cmd_refused)
		else $error("burn of full block not refused");
	AST_USER: assert property (cmd.wr_main && status.user_mode |=> cmd_refused && $stable(main_mirror))
		else $error("user mode write not blocked");
	AST_WR: assert property (cmd.wr_main && status.otp_mode && !burn_busy |=> main_mirror == $past(cmd_data))
		else $error("mirror write lost");
	AST_EXIT: assert property (cmd.exit_debug && cmd_data[14] && !status.otp_mode && status.debug_mode |=> !status.debug_mode ##1 !safe_output_pin)
		else $error("debug exit wrong");
	AST_BURN: assert property ($fell(burn_busy) |-> bcnt_ff == BURN_LEN)
		else $error("burn length wrong");
	AST_DBG: assert property (status.debug_mode |-> !init_timeout)
		else $error("timeout in debug");
	cover property (power_up_start);
	cover property ($fell(burn_busy));
	cover property (cmd_refused);
endmodule
bind otp_mirror_mode_control otp_mirror_chk #(.WIDTH(WIDTH), .TMO_CYC(TMO_CYC), .BURN_LEN(BURN_LEN)) chk
	(.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cmd_data(cmd_data), .safety_fault(safety_fault),
	.main_mirror(main_mirror), .safe_mirror(safe_mirror), .status(status), .cmd_refused(cmd_refused),
	.burn_busy(burn_busy), .main_used(main_used), .regulators_on(regulators_on),
	.power_up_start(power_up_start), .window_enable(window_enable), .init_timeout(init_timeout),
	.safety_reaction(safety_reaction), .safe_output_pin(safe_output_pin));

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import otp_mirror_pkg::*;
	typedef struct {int s; logic [15:0] e; logic [15:0] m;} note_t;
	localparam host_cmd_t bm = 8'h80, bs = 8'h40, wm = 8'h20, ws = 8'h10;
	localparam host_cmd_t xd = 8'h04, xo = 8'h02, et = 8'h01, wu = 8'h08;
	logic         sys_clk, rst, pin, stb, flt, idone, rsta, dss;
	host_cmd_t    cmd;
	logic [15:0]  cdat, mm, sm, d1, d3, ureg;
	mode_status_t st;
	logic         refd, busy, rego, win, tmo, srea, sout, pups;
	sector_t      mu, su;
	note_t        q[$];
	int           num_errors, checks, n;
	host_model host (.sys_clk(sys_clk), .cmd(cmd), .cmd_data(cdat));
	otp_mirror_mode_control #(.TMO_CYC(50)) dut (.sys_clk(sys_clk), .rst(rst),
		.debug_entry_pin(pin), .restart(rsta), .deep_safe_state(dss), .standby(stb),
		.cmd(cmd), .cmd_data(cdat), .safety_fault(flt), .init_done(idone), .main_mirror(mm),
		.safe_mirror(sm), .user_reg(ureg), .status(st), .cmd_refused(refd), .burn_busy(busy),
		.main_used(mu), .safe_used(su), .regulators_on(rego), .power_up_start(pups),
		.window_enable(win), .init_timeout(tmo), .safety_reaction(srea), .safe_output_pin(sout));
	function logic [15:0] view(int s);
		case (s)
			0: return mm;
			1: return sm;
			2: return {11'h0, st};
			3: return {12'h0, mu, su};
			5: return ureg;
			default: return {9'h0, pups, rego, win, tmo, sout, srea, refd};
		endcase
	endfunction
	task note(int s, logic [15:0] e, logic [15:0] m = 16'hFFFF);
		q.push_back('{s, e, m});
	endtask
	task check(logic [15:0] seen, logic [15:0] e);
		checks++;
		if (seen !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, e);
		end
	endtask
	always @(negedge sys_clk)
		while (q.size() > 0)
		begin
			note_t x;
			x = q.pop_front();
			check(view(x.s) & x.m, x.e);
		end
	task results;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cyc(int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// bounded waits: a stuck busy must not hang the run
	task burn(host_cmd_t c);
		host.send(c, 16'h0);
		@(negedge sys_clk);
		for (n = 0; n < 100 && busy === 1'b1; n++)
			@(negedge sys_clk);
		if (n == 100)
			num_errors++;
		cyc(4);
	endtask
	initial
	begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#500000;
		num_errors++;
		results();
	end
	initial
	begin
		void'($urandom(27));
		{rst, pin, stb, flt, idone, rsta, dss} = 7'h60;
		d1 = 16'($urandom);
		d3 = 16'($urandom);
		cyc(12);
		rst <= 0;
		cyc(4);
		note(2, 16'h0E, 16'h1E);
		note(4, 16'h00, 16'h38);
		host.send(wm, d1);
		host.send(ws, 16'h4);
		note(0, d1);
		note(1, 16'h4);
		burn(bm);
		note(3, {12'h0, SEC_FIRST, SEC_NONE});
		note(0, d1);
		host.send(wm, d3);
		burn(bm);
		note(3, {12'h0, SEC_SECOND, SEC_NONE});
		note(0, d3);
		host.send(bm, 16'h0);
		note(4, 16'h1, 16'h1);
		host.send(wm, ~d3);
		note(0, ~d3);
		burn(bs);
		note(3, {12'h0, SEC_SECOND, SEC_FIRST});
		host.send(xd, 16'h4000);
		cyc(1);
		note(2, 16'h0E, 16'h1E);
		host.send(xo, 16'h0);
		note(4, 16'h60, 16'h60);
		note(2, 16'h02, 16'h06);
		host.send(xd, 16'h4000);
		cyc(1);
		note(4, 16'h10, 16'h16);
		cyc(1);
		flt <= 1;
		cyc(1);
		note(4, 16'h16, 16'h16);
		note(2, 16'h00, 16'h02);
		cyc(60);
		note(4, 16'h08, 16'h08);
		host.send(wm, d1);
		note(0, d1);
		flt <= 0;
		stb <= 1;
		cyc(2);
		stb <= 0;
		cyc(6);
		note(0, d3);
		note(4, 16'h00, 16'h20);
		host.send(wm, d1);
		note(0, d1);
		dss <= 1;
		cyc(2);
		dss <= 0;
		cyc(1);
		note(0, d3);
		rst <= 1;
		pin <= 0;
		cyc(3);
		rst <= 0;
		cyc(4);
		note(2, 16'h10, 16'h1E);
		note(0, d3);
		note(3, {12'h0, SEC_SECOND, SEC_FIRST});
		host.send(wm, d1);
		note(4, 16'h1, 16'h1);
		note(0, d3);
		host.send(wu, d3);
		note(5, d3);
		host.send(et, 16'h0);
		cyc(1);
		note(2, 16'h10, 16'h18);
		pin <= 1;
		cyc(4);
		host.send(et, 16'h0);
		cyc(1);
		note(2, 16'h08, 16'h18);
		rsta <= 1;
		cyc(1);
		rsta <= 0;
		cyc(4);
		note(2, 16'h0E, 16'h1E);
		note(4, 16'h00, 16'h20);
		cyc(2);
		results();
	end
endmodule
